//--- fmd_diag_record.sv
// Extended diagnostic record of the frequency-measurement function, read over AXI4-Lite.
// Assumes events and basic record come from logic on sys_clk; AXI master on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fmd_params.svh"

// Sticky flag bank; a set pulse beats a same-cycle clear so no event is lost to a clear
module fmd_sticky_flags #(
  parameter int WIDTH = 4
) (
  // Clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // Set and clear
  input  wire logic [WIDTH-1:0] setPulse,
  input  wire logic [WIDTH-1:0] clrMask,
  // Flag state and its next value
  output logic      [WIDTH-1:0] flags_r,
  output logic      [WIDTH-1:0] flags_nxt
);

  always_comb begin
    flags_nxt = (flags_r & ~clrMask) | setPulse;
  end

  // clkEn low freezes the bank, so an event pulsed meanwhile is not seen
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
    end else if (clkEn) begin
      flags_r <= flags_nxt;
    end
  end

endmodule : fmd_sticky_flags

module fmd_diag_record (
  // Clock, reset, enable
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     clkEn,
  // Register bus
  input  wire fmd_pkg::fmd_axi_req_type axiReq,
  output var  fmd_pkg::fmd_axi_rsp_type axiRsp,
  // Diagnostic sources
  input  wire logic [31:0]              basicRecord,
  input  wire fmd_pkg::fmd_event_type   diagEvent,
  // Interrupt
  output logic                          irq
);

  // Write channel holding
  logic        awHeld_r;
  logic [7:0]  awAddr_r;
  logic        wHeld_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;

  // Read channel
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;

  // Software registers
  logic        moreTypes_r;
  logic [7:0]  irqMask_r;
  logic [7:0]  irqMask_nxt;
  logic [7:0]  irqStatus_r;
  logic [7:0]  irqStatus_nxt;
  logic [7:0]  statusSet;
  logic [7:0]  statusClr;

  // Diagnostic flags
  logic [3:0]  groupErr_r;
  logic [3:0]  groupClr;
  logic [3:0]  lostIrq_r;
  logic [3:0]  lostClr;

  // Handshake terms
  logic        awFire;
  logic        wFire;
  logic        arFire;
  logic        doWrite;
  logic [5:0]  wrIdx;
  logic [5:0]  rdIdx;
  logic        wrLowLane;
  logic        flagClearWr;
  logic        statusRead;
  logic        wrHit;
  logic        ctrlWr;
  logic        maskWr;
  logic [31:0] rdWord;
  logic        rdHit;

  // Ready comes only from an empty holding register, so one write is held at a time; a second may wait behind a pending response
  assign awFire  = clkEn & axiReq.awvalid & ~awHeld_r;
  assign wFire   = clkEn & axiReq.wvalid & ~wHeld_r;
  assign arFire  = clkEn & axiReq.arvalid & ~rValid_r;
  assign doWrite = clkEn & awHeld_r & wHeld_r & ~bValid_r;
  assign wrIdx   = awAddr_r[7:2];
  assign rdIdx   = axiReq.araddr[7:2];
  assign wrLowLane   = wStrb_r[0];
  assign flagClearWr = doWrite & wrLowLane & (wrIdx == `FMD_IDX_FLAG_CLEAR);
  assign statusRead  = arFire & (rdIdx == `FMD_IDX_IRQ_STATUS);
  assign ctrlWr      = doWrite & wrLowLane & (wrIdx == `FMD_IDX_CTRL);
  assign maskWr      = doWrite & wrLowLane & (wrIdx == `FMD_IDX_IRQ_MASK);

  // Ready signals are combinational from held state
  always_comb begin
    axiRsp         = '0;
    axiRsp.awready = ~awHeld_r;
    axiRsp.wready  = ~wHeld_r;
    axiRsp.bvalid  = bValid_r;
    axiRsp.bresp   = bResp_r;
    axiRsp.arready = ~rValid_r;
    axiRsp.rvalid  = rValid_r;
    axiRsp.rdata   = rData_r;
    axiRsp.rresp   = rResp_r;
  end

  // Write address capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
    end else if (awFire) begin
      awHeld_r <= 1'b1;
      awAddr_r <= axiReq.awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  // Write data capture; either channel may arrive first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else if (wFire) begin
      wHeld_r <= 1'b1;
      wData_r <= axiReq.wdata;
      wStrb_r <= axiReq.wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  // Write decode; only holes in the map are refused
  always_comb begin
    wrHit = 1'b0;
    if (wrIdx <= `FMD_IDX_ZERO_LAST) begin
      wrHit = 1'b1;
    end else if (wrIdx == `FMD_IDX_CTRL) begin
      wrHit = 1'b1;
    end else if (wrIdx == `FMD_IDX_IRQ_STATUS) begin
      wrHit = 1'b1;
    end else if (wrIdx == `FMD_IDX_IRQ_MASK) begin
      wrHit = 1'b1;
    end else if (wrIdx == `FMD_IDX_FLAG_CLEAR) begin
      wrHit = 1'b1;
    end
  end

  // Write response; record words ignore writes, unmapped words answer SLVERR
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bValid_r <= 1'b0;
      bResp_r  <= `FMD_RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        bValid_r <= 1'b1;
        if (wrHit) begin
          bResp_r <= `FMD_RESP_OKAY;
        end else begin
          bResp_r <= `FMD_RESP_SLVERR;
        end
      end else if (bValid_r & axiReq.bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      moreTypes_r <= `FMD_CTRL_RESET;
    end else if (ctrlWr) begin
      moreTypes_r <= wData_r[`FMD_CTRL_MORE_BIT];
    end
  end

  // Interrupt mask register; its next value feeds irq so a mask write acts at once
  always_comb begin
    irqMask_nxt = irqMask_r;
    if (maskWr) begin
      irqMask_nxt = wData_r[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqMask_r <= `FMD_MASK_RESET;
    end else if (clkEn) begin
      irqMask_r <= irqMask_nxt;
    end
  end

  // Clear masks: ones written to the clear word, or the whole word on a status read
  assign groupClr  = flagClearWr ? wData_r[`FMD_CLR_GROUP_LSB +: 4] : 4'h0;
  assign lostClr   = flagClearWr ? wData_r[`FMD_CLR_LOST_LSB +: 4] : 4'h0;
  assign statusClr = statusRead ? 8'hFF : 8'h00;
  assign statusSet = {diagEvent.lostIrq, diagEvent.groupErr};

  // Diagnostic flags stay set until software clears them; a record read leaves them
  fmd_sticky_flags #(
    .WIDTH (4)
  ) u_groupErr (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .setPulse  (diagEvent.groupErr),
    .clrMask   (groupClr),
    .flags_r   (groupErr_r),
    .flags_nxt ()
  );

  fmd_sticky_flags #(
    .WIDTH (4)
  ) u_lostIrq (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .setPulse  (diagEvent.lostIrq),
    .clrMask   (lostClr),
    .flags_r   (lostIrq_r),
    .flags_nxt ()
  );

  // Interrupt status: read clears, a same-cycle event still sets
  fmd_sticky_flags #(
    .WIDTH (8)
  ) u_irqStatus (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .setPulse  (statusSet),
    .clrMask   (statusClr),
    .flags_r   (irqStatus_r),
    .flags_nxt (irqStatus_nxt)
  );

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= |(irqStatus_nxt & irqMask_nxt);
    end
  end

  // Read decode of the sixteen record words and the control words
  // Record words sit first so software fetches the whole record as one block
  always_comb begin
    rdWord = 32'h0000_0000;
    rdHit  = 1'b1;
    if (rdIdx == `FMD_IDX_BASIC0) begin
      rdWord[7:0] = basicRecord[7:0];
    end else if (rdIdx == `FMD_IDX_BASIC1) begin
      rdWord[7:0] = basicRecord[15:8];
    end else if (rdIdx == `FMD_IDX_BASIC2) begin
      rdWord[7:0] = basicRecord[23:16];
    end else if (rdIdx == `FMD_IDX_BASIC3) begin
      rdWord[7:0] = basicRecord[31:24];
    end else if (rdIdx == `FMD_IDX_CHTYPE) begin
      rdWord[6:0] = `FMD_CHTYPE_CODE;
      rdWord[7]   = moreTypes_r;
    end else if (rdIdx == `FMD_IDX_DIAGBITS) begin
      rdWord[7:0] = `FMD_DIAG_BITS;
    end else if (rdIdx == `FMD_IDX_CHCOUNT) begin
      rdWord[7:0] = `FMD_CHANNELS;
    end else if (rdIdx == `FMD_IDX_GROUPERR) begin
      rdWord[3:0] = groupErr_r;
    end else if (rdIdx == `FMD_IDX_LOST0) begin
      rdWord[0] = lostIrq_r[0];
    end else if (rdIdx == `FMD_IDX_LOST1) begin
      rdWord[0] = lostIrq_r[1];
    end else if (rdIdx == `FMD_IDX_LOST2) begin
      rdWord[0] = lostIrq_r[2];
    end else if (rdIdx == `FMD_IDX_LOST3) begin
      rdWord[0] = lostIrq_r[3];
    end else if ((rdIdx >= `FMD_IDX_ZERO_FIRST) && (rdIdx <= `FMD_IDX_ZERO_LAST)) begin
      rdWord = 32'h0000_0000;
    end else if (rdIdx == `FMD_IDX_CTRL) begin
      rdWord[`FMD_CTRL_MORE_BIT] = moreTypes_r;
    end else if (rdIdx == `FMD_IDX_IRQ_STATUS) begin
      rdWord[7:0] = irqStatus_r;
    end else if (rdIdx == `FMD_IDX_IRQ_MASK) begin
      rdWord[7:0] = irqMask_r;
    end else if (rdIdx == `FMD_IDX_FLAG_CLEAR) begin
      rdWord = 32'h0000_0000;
    end else begin
      rdHit = 1'b0;
    end
  end

  // Read valid: one read in flight, arready stays low until the data is taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rValid_r <= 1'b0;
    end else if (clkEn) begin
      if (arFire) begin
        rValid_r <= 1'b1;
      end else if (rValid_r & axiReq.rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  // Read data is captured once and held until taken, so a flag
  // changing mid-transfer never tears the returned word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rData_r <= 32'h0000_0000;
      rResp_r <= `FMD_RESP_OKAY;
    end else if (arFire) begin
      rData_r <= rdWord;
      rResp_r <= rdHit ? `FMD_RESP_OKAY : `FMD_RESP_SLVERR;
    end
  end

endmodule : fmd_diag_record

`default_nettype wire

//--- fmd_diag_record_asserts.sv
// Checker for the record read path of the diagnostic record block.
// Assumes it is bound onto fmd_diag_record; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "fmd_params.svh"
module fmd_diag_record_chk (
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire logic                     clkEn,
  // Register bus
  input wire fmd_pkg::fmd_axi_req_type axiReq,
  input wire fmd_pkg::fmd_axi_rsp_type axiRsp,
  // Sources and interrupt
  input wire logic [31:0]              basicRecord,
  input wire fmd_pkg::fmd_event_type   diagEvent,
  input wire logic                     irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       arTake;
  logic [5:0] arIdx;
  assign arTake = axiReq.arvalid && axiRsp.arready && clkEn;
  assign arIdx  = axiReq.araddr[7:2];
  AST_READ_ANSWER: assert property (arTake |=> axiRsp.rvalid)
    else $error("read not answered one cycle after address");
  // Snapshot at the address edge keeps a record read coherent
  AST_READ_HOLD: assert property (axiRsp.rvalid && !(axiReq.rready && clkEn)
    |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read data moved before taken");
  AST_BASIC_BYTE: assert property (arTake && arIdx < 6'h04
    |=> axiRsp.rdata == (($past(basicRecord) >> (8 * $past(arIdx[1:0]))) & 32'h000000FF))
    else $error("basic byte wrong");
  AST_CHTYPE: assert property (arTake && arIdx == `FMD_IDX_CHTYPE
    |=> axiRsp.rdata[6:0] == `FMD_CHTYPE_CODE && axiRsp.rdata[31:8] == 24'h000000)
    else $error("channel type wrong");
  AST_DIAG_BITS: assert property (arTake && arIdx == `FMD_IDX_DIAGBITS
    |=> axiRsp.rdata == {24'h000000, `FMD_DIAG_BITS}) else $error("bits per channel wrong");
  AST_CH_COUNT: assert property (arTake && arIdx == `FMD_IDX_CHCOUNT
    |=> axiRsp.rdata == {24'h000000, `FMD_CHANNELS}) else $error("channel count wrong");
  AST_GROUP_UPPER: assert property (arTake && arIdx == `FMD_IDX_GROUPERR
    |=> axiRsp.rdata[31:4] == 28'h0000000) else $error("group error upper bits set");
  AST_LOST_UPPER: assert property (arTake && arIdx[5:2] == 4'h2
    |=> axiRsp.rdata[31:1] == 31'h00000000) else $error("lost flag upper bits set");
  AST_TAIL_ZERO: assert property (arTake && arIdx[5:2] == 4'h3
    |=> axiRsp.rdata == 32'h00000000) else $error("tail byte not zero");
endmodule : fmd_diag_record_chk
bind fmd_diag_record fmd_diag_record_chk u_chk (.sys_clk, .rst, .clkEn, .axiReq, .axiRsp,
  .basicRecord, .diagEvent, .irq);
`default_nettype wire

//--- fmd_params.svh
// Constants for the frequency-meter diagnostic record block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef FMD_PARAMS_SVH
`define FMD_PARAMS_SVH

// Register indices; byte address is four times the index
`define FMD_IDX_BASIC0      6'h00
`define FMD_IDX_BASIC1      6'h01
`define FMD_IDX_BASIC2      6'h02
`define FMD_IDX_BASIC3      6'h03
`define FMD_IDX_CHTYPE      6'h04
`define FMD_IDX_DIAGBITS    6'h05
`define FMD_IDX_CHCOUNT     6'h06
`define FMD_IDX_GROUPERR    6'h07
`define FMD_IDX_LOST0       6'h08
`define FMD_IDX_LOST1       6'h09
`define FMD_IDX_LOST2       6'h0A
`define FMD_IDX_LOST3       6'h0B
`define FMD_IDX_ZERO_FIRST  6'h0C
`define FMD_IDX_ZERO_LAST   6'h0F
`define FMD_IDX_CTRL        6'h10
`define FMD_IDX_IRQ_STATUS  6'h11
`define FMD_IDX_IRQ_MASK    6'h12
`define FMD_IDX_FLAG_CLEAR  6'h13

// Fixed record contents
`define FMD_CHTYPE_CODE     7'h76
`define FMD_DIAG_BITS       8'h08
`define FMD_CHANNELS        8'h04

// Field positions
`define FMD_CTRL_MORE_BIT   0
`define FMD_CLR_GROUP_LSB   0
`define FMD_CLR_LOST_LSB    4

// Reset values
`define FMD_CTRL_RESET      1'h0
`define FMD_MASK_RESET      8'h00

// AXI responses
`define FMD_RESP_OKAY       2'h0
`define FMD_RESP_SLVERR     2'h2

`endif

//--- fmd_pkg.sv
// Types shared by the frequency-meter diagnostic record block.
// Assumes an AXI4-Lite master with 8-bit addresses and 32-bit data.
package fmd_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } fmd_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fmd_axi_rsp_type;

  // One-cycle event pulses from the four frequency meters
  typedef struct packed {
    logic [3:0] lostIrq;
    logic [3:0] groupErr;
  } fmd_event_type;

endpackage : fmd_pkg

//--- test_fmd_diag_record.sv
// Self-checking bench for the diagnostic record block.
// Assumes the checker is bound; bus changes right after rising edges.
`timescale 1ns/1ps
`default_nettype none
module test_fmd_diag_record;
  logic                     sys_clk;
  logic                     rst;
  logic                     clkEn;
  fmd_pkg::fmd_axi_req_type axiReq;
  fmd_pkg::fmd_axi_rsp_type axiRsp;
  logic [31:0]              basicRecord;
  fmd_pkg::fmd_event_type   diagEvent;
  logic                     irq;
  logic [31:0]              rd;
  logic [1:0]               rs;
  int                       fail_count;
  int                       tests_run;
  fmd_diag_record u_dut (.sys_clk, .rst, .clkEn, .axiReq, .axiRsp, .basicRecord, .diagEvent, .irq);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdReg(input logic [7:0] a);
    @(posedge sys_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do @(posedge sys_clk); while (axiRsp.arready !== 1'b1);
    axiReq.arvalid <= 1'b0;
    do @(posedge sys_clk); while (axiRsp.rvalid !== 1'b1);
    rd = axiRsp.rdata;
    rs = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : rdReg
  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] e);
    rdReg(a);
    chk(n, e, rd);
  endtask : rdChk
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiReq.awvalid || axiReq.wvalid);
    do @(posedge sys_clk); while (axiRsp.bvalid !== 1'b1);
    rs = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask : wrReg
  // Pulse lasts one cycle; the last edge lets the registered irq settle
  task automatic pulse(input logic [7:0] e);
    @(posedge sys_clk);
    diagEvent <= e;
    @(posedge sys_clk);
    diagEvent <= 8'h00;
    @(posedge sys_clk);
  endtask : pulse
  task automatic print_verdict;
    $display("counts run %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #500000;
    fail_count++;
    print_verdict;
  end
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    axiReq = '0;
    diagEvent = '0;
    basicRecord = 32'hA1B2C3D4;
    fail_count = 0;
    tests_run = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdChk("basic", 8'(4 * i), (basicRecord >> (8 * i)) & 32'hFF);
    rdChk("chtype", 8'h10, 32'h76);
    rdChk("diagbits", 8'h14, 32'h08);
    rdChk("chcount", 8'h18, 32'h04);
    for (int i = 12; i < 16; i++) rdChk("tail", 8'(4 * i), 32'h0);
    wrReg(8'h14, 32'hFFFFFFFF);
    chk("ro wr resp", 32'h0, {30'h0, rs});
    rdChk("ro write", 8'h14, 32'h08);
    $display("test layout done");
    wrReg(8'h40, 32'h1);
    rdChk("more", 8'h10, 32'hF6);
    wrReg(8'h40, 32'h0);
    rdChk("none", 8'h10, 32'h76);
    $display("test types done");
    wrReg(8'h48, 32'hFF);
    pulse(8'h5A);
    chk("irq on", 32'h1, {31'h0, irq});
    rdChk("group", 8'h1C, 32'h0A);
    for (int i = 0; i < 4; i++) rdChk("lost", 8'(32 + 4 * i), {31'h0, !i[0]});
    rdChk("status", 8'h44, 32'h5A);
    rdChk("status clr", 8'h44, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    rdChk("sticky", 8'h1C, 32'h0A);
    wrReg(8'h4C, 32'hFF);
    rdChk("group clr", 8'h1C, 32'h0);
    rdChk("lost clr", 8'h20, 32'h0);
    $display("test events done");
    wrReg(8'h48, 32'h0);
    pulse(8'h81);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdChk("lost3", 8'h2C, 32'h1);
    rdChk("status m", 8'h44, 32'h81);
    rdReg(8'h80);
    chk("resp", 32'h2, {30'h0, rs});
    chk("unmapped", 32'h0, rd);
    wrReg(8'h80, 32'h1);
    chk("wr resp", 32'h2, {30'h0, rs});
    $display("test mask done");
    clkEn <= 1'b0;
    pulse(8'h0F);
    clkEn <= 1'b1;
    rdChk("frozen", 8'h1C, 32'h01);
    basicRecord <= 32'h5E6F7081;
    rdChk("basic live", 8'h0C, 32'h5E);
    wrReg(8'h40, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdChk("ctrl rst", 8'h40, 32'h0);
    rdChk("lost rst", 8'h2C, 32'h0);
    $display("test freeze and reset done");
    print_verdict;
  end
endmodule : test_fmd_diag_record
`default_nettype wire
